/* pkg/adc_out_consts.svh */
// Register offsets, field positions, reset values and latencies.
`ifndef ADC_OUT_CONSTS_SVH
`define ADC_OUT_CONSTS_SVH
// ==========================================================
// Register offsets
`define OFS_DECIM 7'h00
`define OFS_PERF 7'h01
`define OFS_THR 7'h05
`define OFS_PAT_A 7'h3c
`define OFS_PAT_B 7'h3d
`define OFS_PAT_C 7'h3e
// ==========================================================
// Field positions
`define POS_DECIM 14
`define POS_CORR 15
`define POS_PERF 1
`define POS_PAT_EN 15
`define PAT_MSB 13
`define PAT_LSB 2
`define THR_MSB 3
// ==========================================================
// Reset values
`define RST_PERF 1'b1
`define RST_THR 4'hf
`define RST_WORD 16'h0000
// ==========================================================
// Latencies and limits
`define LAT_PLAIN 7'd38
`define LAT_CORR 7'd50
`define LAT_DECIM 7'd74
`define LAT_OVR 12
`define DLY_DEPTH 73
`define FULL_SCALE 12'h7ff
`define SER_ADDR_LAST 5'd7
`define SER_FRAME_LAST 5'd23
`define AGE_MAX 7'h7f
`endif

/* pkg/adc_out_pkg.sv */
// Types shared by the converter output stage.
package adc_out_pkg;
	typedef logic [11:0] sample_t;
	typedef logic [15:0] reg_word_t;
	typedef logic [6:0] reg_addr_t;
	typedef enum logic [3:0]
	{
		SER_ADDR  = 4'h1,
		SER_WRITE = 4'h2,
		SER_READ  = 4'h4,
		SER_DONE  = 4'h8
	} ser_state_t;
endpackage

/* src/adc_output_pattern_overrange.sv */
// Converter output stage: latency, test patterns, overrange, serial port.
// How it works
// R1 - Correction and decimation off: sample reaches output bus 38 cycles later.
// R2 - Correction on, decimation off: sample reaches output bus 50 cycles later.
// R3 - Decimation on, correction off: latency is 74 cycles.
// R4 - Overrange flag follows its sample by 12 cycles.
// R5 - Host clears perf_mode_one before choosing a pattern.
// R6 - Host writes all three pattern registers consistently.
// R7 - Pattern codes give constant all-zero or all-one words.
// R8 - Codes 0x9554/0x2aa8/0x1554 alternate 0xaaa and 0x555.
// R9 - Codes 0xbffc/0x0000/0x3ffc alternate 0xfff and 0x000.
// R10 - Custom pattern outputs bits 13 to 2 of second register.
// R11 - Host restores perf_mode_one and zeroes pattern registers.
// R12 - Flag when magnitude exceeds full scale times threshold over 16.
// R13 - Threshold field resets to 15.
// R14 - Threshold is written serially; flag drives its own output.
// R15 - Host holds reset low at least 20 ns.
// R16 - Host waits 3 ms after power before reset.
// R17 - Host waits 100 ns after reset before selecting serial port.
// R18 - Serial clock stays at or below 20 MHz.
// R19 - Words leave on a double rate bus with forwarded clock.
// R20 - Serial frame: 8-bit address, top bit read, then 16-bit data.
// R21 - Reset returns every configuration register to its default.
// R22 - Selected pattern replaces samples; output clock keeps running.
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module adc_output_pattern_overrange
(
	input  wire logic                 i_clock,
	input  wire logic                 i_reset_n,
	input  wire adc_out_pkg::sample_t i_sample_in,
	input  wire logic                 i_serial_clock,
	input  wire logic                 i_serial_select_n,
	input  wire logic                 i_serial_data_in,
	output logic                      o_serial_data_out,
	output logic                      o_serial_data_oe,
	output adc_out_pkg::sample_t      o_sample_out_bus,
	output logic                      o_forwarded_output_clock,
	output logic                      o_overrange_flag_out
);
	import adc_out_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic over_thr(input sample_t s,
		input logic [3:0] th);
		logic [11:0] mag;
		logic [15:0] lhs;
		logic [15:0] rhs;
		mag = s[11] ? 12'(-s) : s;
		lhs = {mag, 4'h0};
		rhs = {4'h0, `FULL_SCALE} * {12'h0, th};
		return lhs > rhs;
	endfunction

	// ==========================================================
	// Declarations
	logic        decim_ff;
	logic        corr_ff;
	logic        perf_mode_one_ff;
	logic [3:0]  overrange_threshold_field_ff;
	reg_word_t   pat_a_ff;
	reg_word_t   pat_b_ff;
	reg_word_t   pat_c_ff;
	ser_state_t  ser_st_ff;
	logic [4:0]  ser_cnt_ff;
	logic [22:0] ser_sh_ff;
	reg_word_t   rd_sh_ff;
	reg_addr_t   wr_addr_ff;
	reg_word_t   wr_data_ff;
	logic        wr_tgl_ff;
	logic        tgl_s1_ff;
	logic        tgl_s2_ff;
	logic        tgl_s3_ff;
	logic        tgl_seen_ff;
	logic        wr_evt;
	logic        wr_idle;
	sample_t     dly_ff [0:`DLY_DEPTH-1];
	logic [`LAT_OVR-2:0] ovr_dly_ff;
	logic [6:0]  lat;
	logic        pat_on;
	logic        pat_const;
	sample_t     pat_a;
	sample_t     pat_b;
	logic        phase_ff;
	sample_t     nxt_bus;
	logic [6:0]  age_ff;
	reg_word_t   rd_word;
	reg_addr_t   rd_addr;

	// ==========================================================
	// Serial port, on the serial clock
	// The frame logic is cleared by the select pin itself, since
	// the serial clock may stand still between frames.
	always_ff @(posedge i_serial_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ser_sh_ff <= 23'h0;
		else
			ser_sh_ff <= {ser_sh_ff[21:0], i_serial_data_in};
	end

	assign rd_addr = {ser_sh_ff[5:0], i_serial_data_in};

	// Register words are read straight across the domains. They
	// change only by a serial write or by reset, neither of which
	// may overlap a read frame, so they are static while sampled.
	always_comb
	begin
		case (rd_addr)
			`OFS_DECIM: rd_word = reg_word_t'(decim_ff) << `POS_DECIM;
			`OFS_PERF:
				rd_word = (reg_word_t'(corr_ff) << `POS_CORR)
					| (reg_word_t'(perf_mode_one_ff) << `POS_PERF);
			`OFS_THR: rd_word = {12'h0, overrange_threshold_field_ff};
			`OFS_PAT_A: rd_word = pat_a_ff;
			`OFS_PAT_B: rd_word = pat_b_ff;
			`OFS_PAT_C: rd_word = pat_c_ff;
			default: rd_word = `RST_WORD;
		endcase
	end

	always_ff @(posedge i_serial_clock or negedge i_reset_n
		or posedge i_serial_select_n)
	begin
		if (!i_reset_n || i_serial_select_n)
		begin
			ser_cnt_ff <= 5'h0;
			ser_st_ff <= SER_ADDR;
			o_serial_data_oe <= 1'b0;
			o_serial_data_out <= 1'b0;
			rd_sh_ff <= `RST_WORD;
		end
		else
		begin
			if (ser_st_ff != SER_DONE)
				ser_cnt_ff <= ser_cnt_ff + 5'h1;
			case (ser_st_ff)
				SER_ADDR:
					if (ser_cnt_ff == `SER_ADDR_LAST)
					begin
						if (ser_sh_ff[6]) // [R20]
						begin
							ser_st_ff <= SER_READ;
							o_serial_data_oe <= 1'b1;
							o_serial_data_out <= rd_word[15];
							rd_sh_ff <= {rd_word[14:0], 1'b0};
						end
						else
							ser_st_ff <= SER_WRITE;
					end
				SER_WRITE:
					if (ser_cnt_ff == `SER_FRAME_LAST)
						ser_st_ff <= SER_DONE;
				SER_READ:
				begin
					o_serial_data_out <= rd_sh_ff[15];
					rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
					if (ser_cnt_ff == `SER_FRAME_LAST)
						ser_st_ff <= SER_DONE;
				end
				SER_DONE: ser_st_ff <= SER_DONE;
				default: ser_st_ff <= SER_ADDR;
			endcase
		end
	end

	// A finished write is held and announced by a toggle.
	always_ff @(posedge i_serial_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_addr_ff <= 7'h0;
			wr_data_ff <= `RST_WORD;
			wr_tgl_ff <= 1'b0;
		end
		else if (ser_st_ff == SER_WRITE
			&& ser_cnt_ff == `SER_FRAME_LAST) // [R20]
		begin
			wr_addr_ff <= ser_sh_ff[21:15];
			wr_data_ff <= {ser_sh_ff[14:0], i_serial_data_in};
			wr_tgl_ff <= ~wr_tgl_ff;
		end
	end

	// ==========================================================
	// Write crossing into the sample clock
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			tgl_s1_ff <= 1'b0;
			tgl_s2_ff <= 1'b0;
			tgl_s3_ff <= 1'b0;
		end
		else
		begin
			tgl_s1_ff <= wr_tgl_ff;
			tgl_s2_ff <= tgl_s1_ff;
			tgl_s3_ff <= tgl_s2_ff;
		end
	end

	assign wr_evt = (tgl_s2_ff == tgl_s3_ff) && (tgl_s3_ff != tgl_seen_ff);

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			tgl_seen_ff <= 1'b0;
		else if (wr_evt)
			tgl_seen_ff <= tgl_s3_ff;
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n) // [R21] [R13]
		begin
			decim_ff <= 1'b0;
			corr_ff <= 1'b0;
			perf_mode_one_ff <= `RST_PERF;
			overrange_threshold_field_ff <= `RST_THR;
			pat_a_ff <= `RST_WORD;
			pat_b_ff <= `RST_WORD;
			pat_c_ff <= `RST_WORD;
		end
		else if (wr_evt)
		begin
			case (wr_addr_ff)
				`OFS_DECIM: decim_ff <= wr_data_ff[`POS_DECIM];
				`OFS_PERF:
				begin
					corr_ff <= wr_data_ff[`POS_CORR];
					perf_mode_one_ff <= wr_data_ff[`POS_PERF];
				end
				`OFS_THR: // [R14]
					overrange_threshold_field_ff <= wr_data_ff[`THR_MSB:0];
				`OFS_PAT_A: pat_a_ff <= wr_data_ff;
				`OFS_PAT_B: pat_b_ff <= wr_data_ff;
				`OFS_PAT_C: pat_c_ff <= wr_data_ff;
				default: decim_ff <= decim_ff;
			endcase
		end
	end

	// ==========================================================
	// Sample delay line and latency select
	always_ff @(posedge i_clock)
	begin
		dly_ff[0] <= i_sample_in;
		for (int i = 1; i < `DLY_DEPTH; i++)
			dly_ff[i] <= dly_ff[i-1];
	end

	always_comb
	begin
		if (decim_ff)
			lat = `LAT_DECIM; // [R3]
		else if (corr_ff)
			lat = `LAT_CORR; // [R2]
		else
			lat = `LAT_PLAIN; // [R1]
	end

	// ==========================================================
	// Test patterns
	// Pattern mode needs the performance bit clear; the host is
	// expected to have done so before writing the pattern words.
	assign pat_on = !perf_mode_one_ff && pat_a_ff[`POS_PAT_EN]; // [R5]
	assign pat_a = pat_a_ff[`PAT_MSB:`PAT_LSB];
	assign pat_b = pat_b_ff[`PAT_MSB:`PAT_LSB];
	assign pat_const = (pat_a == 12'h0)
		&& (pat_c_ff[`PAT_MSB:`PAT_LSB] == 12'h0); // [R10]

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			phase_ff <= 1'b0;
		else
			phase_ff <= ~phase_ff;
	end

	always_comb
	begin
		if (!pat_on)
			nxt_bus = dly_ff[lat - 7'd2];
		else if (pat_const || phase_ff)
			nxt_bus = pat_b; // [R7] [R10]
		else
			nxt_bus = pat_a; // [R8] [R9]
	end

	// ==========================================================
	// Output bus and forwarded clock
	// One word per sample clock, so the forwarded clock toggles on
	// every rising edge and each of its transitions carries one word.
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			o_sample_out_bus <= 12'h0;
		else
			o_sample_out_bus <= nxt_bus; // [R22]
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			o_forwarded_output_clock <= 1'b0;
		else
			o_forwarded_output_clock <= ~o_forwarded_output_clock; // [R19]
	end

	// ==========================================================
	// Overrange detection
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			ovr_dly_ff <= '0;
			o_overrange_flag_out <= 1'b0;
		end
		else
		begin
			ovr_dly_ff <= {ovr_dly_ff[`LAT_OVR-3:0],
				over_thr(i_sample_in, overrange_threshold_field_ff)}; // [R12]
			o_overrange_flag_out <= ovr_dly_ff[`LAT_OVR-2]; // [R4] [R14]
		end
	end

	// ==========================================================
	// Checks
	// A write still crossing could change the pattern inside a checked
	// window, so the pattern checks start only while none is in flight.
	assign wr_idle = (tgl_s1_ff == tgl_seen_ff)
		&& (tgl_s2_ff == tgl_seen_ff) && (tgl_s3_ff == tgl_seen_ff);

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n || wr_evt)
			age_ff <= 7'h0;
		else if (age_ff != `AGE_MAX)
			age_ff <= age_ff + 7'h1;
	end

	property p_lat_plain;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd80 && !pat_on && !corr_ff && !decim_ff)
		|-> o_sample_out_bus == $past(i_sample_in, `LAT_PLAIN);
	endproperty
	a_lat_plain: assert property (p_lat_plain) // [R1]
		else $error("Plain latency is not 38 cycles.");

	property p_lat_corr;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd80 && !pat_on && corr_ff && !decim_ff)
		|-> o_sample_out_bus == $past(i_sample_in, `LAT_CORR);
	endproperty
	a_lat_corr: assert property (p_lat_corr) // [R2]
		else $error("Corrected latency is not 50 cycles.");

	property p_lat_decim;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd80 && !pat_on && decim_ff)
		|-> o_sample_out_bus == $past(i_sample_in, `LAT_DECIM);
	endproperty
	a_lat_decim: assert property (p_lat_decim) // [R3]
		else $error("Decimation latency is not 74 cycles.");

	property p_ovr_lat;
		@(posedge i_clock) disable iff (!i_reset_n)
		age_ff > 7'd20 |-> o_overrange_flag_out == over_thr(
			$past(i_sample_in, `LAT_OVR), overrange_threshold_field_ff);
	endproperty
	a_ovr_lat: assert property (p_ovr_lat) // [R4]
		else $error("Overrange flag is not 12 cycles after sample.");

	property p_ovr_full;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd20 && overrange_threshold_field_ff == `RST_THR)
		|-> ($past(i_sample_in, `LAT_OVR) == `FULL_SCALE
			|-> o_overrange_flag_out)
		and ($past(i_sample_in, `LAT_OVR) == 12'h0
			|-> !o_overrange_flag_out);
	endproperty
	a_ovr_full: assert property (p_ovr_full) // [R12]
		else $error("Overrange trip point is wrong.");

	property p_rst_dflt;
		@(posedge i_clock) disable iff (!i_reset_n)
		$rose(i_reset_n) |-> overrange_threshold_field_ff == `RST_THR
			&& perf_mode_one_ff && !corr_ff && !decim_ff
			&& pat_a_ff == `RST_WORD && pat_b_ff == `RST_WORD;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt) // [R13] [R21]
		else $error("Register defaults wrong after reset.");

	property p_thr_wr;
		@(posedge i_clock) disable iff (!i_reset_n)
		(wr_evt && wr_addr_ff == `OFS_THR) |=>
			overrange_threshold_field_ff == $past(wr_data_ff[`THR_MSB:0]);
	endproperty
	a_thr_wr: assert property (p_thr_wr) // [R14]
		else $error("Threshold write did not take effect.");

	sequence s_hold_b;
		(o_sample_out_bus == pat_b) [*3];
	endsequence

	property p_pat_const;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd3 && wr_idle && pat_on && pat_const) |-> s_hold_b;
	endproperty
	a_pat_const: assert property (p_pat_const) // [R7] [R10]
		else $error("Constant pattern word not held.");

	sequence s_alt;
		(o_sample_out_bus == pat_a ##1 o_sample_out_bus == pat_b)
		or (o_sample_out_bus == pat_b ##1 o_sample_out_bus == pat_a);
	endsequence

	property p_pat_alt;
		@(posedge i_clock) disable iff (!i_reset_n)
		(age_ff > 7'd3 && wr_idle && pat_on && !pat_const) |-> s_alt;
	endproperty
	a_pat_alt: assert property (p_pat_alt) // [R8] [R9]
		else $error("Toggle pattern does not alternate.");

	property p_clk_run;
		@(posedge i_clock) disable iff (!i_reset_n)
		$past(i_reset_n) |-> o_forwarded_output_clock
			!= $past(o_forwarded_output_clock);
	endproperty
	a_clk_run: assert property (p_clk_run) // [R19] [R22]
		else $error("Forwarded clock missed a transition.");

	property p_rd_oe;
		@(posedge i_serial_clock)
		disable iff (!i_reset_n || i_serial_select_n)
		(ser_st_ff == SER_ADDR && ser_cnt_ff == `SER_ADDR_LAST
			&& ser_sh_ff[6]) |=> o_serial_data_oe ##1 o_serial_data_oe;
	endproperty
	a_rd_oe: assert property (p_rd_oe) // [R20]
		else $error("Read frame did not drive data pin.");
endmodule

/* tb/rx_capture.sv */
// Receiving logic model that captures the double rate sample bus.
`timescale 1ns/1ps
module rx_capture
(
	input  wire logic                 i_fwd_clock,
	input  wire adc_out_pkg::sample_t i_bus,
	output adc_out_pkg::sample_t      o_word,
	output int unsigned               o_edges
);
	import adc_out_pkg::*;
	// ==========================================================
	// Capture
	// Both transitions carry a word; the bus is read once it has settled,
	// since the model cannot rely on process order at the edge itself.
	initial
	begin
		o_word = '0;
		o_edges = 0;
		forever
		begin
			@(i_fwd_clock);
			#1;
			o_word = i_bus;
			o_edges = o_edges + 1;
		end
	end
endmodule

/* tb/adc_output_pattern_overrange_bench.sv */
// Self-checking bench for the converter output stage.
`timescale 1ns/1ps
`include "adc_out_consts.svh"
module adc_output_pattern_overrange_bench;
	import adc_out_pkg::*;
	// ==========================================================
	// Stimulus and instances
	logic        i_clock = 0;
	logic        i_reset_n = 0;
	sample_t     i_sample_in = '0;
	logic        sclk = 0;
	logic        sel_n = 1;
	logic        sbit = 0;
	logic        hdrv = 1;
	wire logic   dio;
	logic        dq_out;
	logic        dq_oe;
	logic        fclk;
	logic        ovr;
	sample_t     bus;
	sample_t     word;
	int unsigned edges;
	int          cyc = 0;
	int          n_mismatch = 0;
	int          compares = 0;
	always #25 i_clock = ~i_clock;
	// A released data pin toggles, so a stale bit can never pass.
	assign dio = dq_oe ? dq_out : (hdrv ? sbit : cyc[0]);
	function automatic sample_t fs(input int c);
		return sample_t'(c * 179);
	endfunction
	function automatic int mag(input sample_t s);
		return s[11] ? 4096 - int'(s) : int'(s);
	endfunction
	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		i_sample_in <= fs(cyc + 1);
	end
	adc_output_pattern_overrange i_adc_output_pattern_overrange
	(
		.i_clock                  (i_clock),
		.i_reset_n                (i_reset_n),
		.i_sample_in              (i_sample_in),
		.i_serial_clock           (sclk),
		.i_serial_select_n        (sel_n),
		.i_serial_data_in         (dio),
		.o_serial_data_out        (dq_out),
		.o_serial_data_oe         (dq_oe),
		.o_sample_out_bus         (bus),
		.o_forwarded_output_clock (fclk),
		.o_overrange_flag_out     (ovr)
	);
	rx_capture i_rx_capture
	(
		.i_fwd_clock (fclk),
		.i_bus       (bus),
		.o_word      (word),
		.o_edges     (edges)
	);
	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// The serial clock runs only inside a frame, just under 20 MHz.
	task automatic ser(input logic rd, input reg_addr_t a,
		input reg_word_t d, output reg_word_t q);
		logic [23:0] f;
		f = {rd, a, d};
		q = '0;
		sel_n <= 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sbit <= f[i];
			if (rd && i < 16)
				hdrv <= 1'b0;
			#26;
			if (rd && i < 16)
				q[i] = dio;
			sclk <= 1'b1;
			#26;
			sclk <= 1'b0;
		end
		sel_n <= 1'b1;
		hdrv <= 1'b1;
		#400;
	endtask
	task automatic wr(input reg_addr_t a, input reg_word_t d);
		reg_word_t q;
		ser(1'b0, a, d, q);
	endtask
	task automatic rdchk(input reg_addr_t a, input reg_word_t e);
		reg_word_t q;
		ser(1'b1, a, 16'h0000, q);
		chk("register", e, q);
	endtask
	task automatic lat(input int l);
		repeat (90) @(posedge i_clock);
		repeat (6)
		begin
			@(negedge i_clock);
			chk("bus", {4'h0, fs(cyc - l)}, {4'h0, word});
		end
	endtask
	task automatic ovr_chk(input int thr);
		repeat (10) @(posedge i_clock);
		repeat (150)
		begin
			@(negedge i_clock);
			chk("ovr", {15'h0, mag(fs(cyc - 12)) * 16 > 2047 * thr},
				{15'h0, ovr});
		end
	endtask
	task automatic pat(input reg_word_t a, b, c, input sample_t w0, w1);
		sample_t     x;
		sample_t     y;
		int unsigned e;
		wr(`OFS_PAT_A, a);
		wr(`OFS_PAT_B, b);
		wr(`OFS_PAT_C, c);
		repeat (10) @(posedge i_clock);
		@(negedge i_clock);
		x = word;
		e = edges;
		@(negedge i_clock);
		y = word;
		chk("pattern", {4'h0, (x === w1) ? w1 : w0}, {4'h0, x});
		chk("pattern", {4'h0, (x === w1) ? w0 : w1}, {4'h0, y});
		repeat (20) @(negedge i_clock);
		chk("edges", 16'd21, 16'(edges - e));
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_registers;
		rdchk(`OFS_PERF, 16'h0002);
		rdchk(`OFS_THR, 16'h000f);
		wr(7'h10, 16'hffff);
		rdchk(7'h10, 16'h0000);
		wr(`OFS_PAT_B, 16'h1234);
		rdchk(`OFS_PAT_B, 16'h1234);
		wr(`OFS_PAT_B, 16'h0000);
	endtask
	task automatic t_latency;
		lat(38);
		wr(`OFS_PERF, 16'h8002);
		lat(50);
		wr(`OFS_PERF, 16'h0002);
		wr(`OFS_DECIM, 16'h4000);
		lat(74);
		wr(`OFS_DECIM, 16'h0000);
	endtask
	task automatic t_overrange;
		ovr_chk(15);
		wr(`OFS_THR, 16'h0000);
		ovr_chk(0);
		wr(`OFS_THR, 16'h0008);
		ovr_chk(8);
	endtask
	task automatic t_patterns;
		wr(`OFS_PERF, 16'h0000);
		pat(16'h8000, 16'h0000, 16'h0000, 12'h000, 12'h000);
		pat(16'hbffc, 16'h3ffc, 16'h3ffc, 12'hfff, 12'hfff);
		pat(16'h9554, 16'h2aa8, 16'h1554, 12'haaa, 12'h555);
		pat(16'hbffc, 16'h0000, 16'h3ffc, 12'hfff, 12'h000);
		pat(16'h8000, 16'h270c, 16'h0000, 12'h9c3, 12'h9c3);
		wr(`OFS_PERF, 16'h0002);
		wr(`OFS_PAT_A, 16'h0000);
		wr(`OFS_PAT_B, 16'h0000);
		wr(`OFS_PAT_C, 16'h0000);
		lat(38);
	endtask
	task automatic t_reset_mid;
		while ($realtime < 3000000.0)
			@(posedge i_clock);
		@(posedge i_clock);
		i_reset_n <= 1'b0;
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		#200;
		rdchk(`OFS_THR, 16'h000f);
		rdchk(`OFS_PERF, 16'h0002);
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (8) @(posedge i_clock);
		i_reset_n <= 1'b1;
		#200;
		t_registers;
		t_latency;
		t_overrange;
		t_patterns;
		t_reset_mid;
		report_and_stop;
	end
	// The second reset waits until 3 ms have passed, so a clean run takes
	// just over 3 ms; 4 ms leaves margin and equals 80000 cycles.
	initial
	begin
		#4000000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
